// >>> common/ssp_defines.svh
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define SSP_ADDR_CTRL   4'h0
`define SSP_ADDR_STATUS 4'h4
`define SSP_ADDR_CONFIG 4'h8
`define SSP_ADDR_DATA   4'hC

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SSP_CTRL_RATE_LO 0
`define SSP_CTRL_RATE_HI 1
`define SSP_CTRL_SEL     2
`define SSP_CTRL_IRQ_EN  3
`define SSP_STAT_BUSY    0
`define SSP_STAT_DONE    1
`define SSP_CFG_PIN4     4
`define SSP_CFG_PIN5     5
`define SSP_CFG_PIN6     6

// ------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------
`define SSP_CTRL_RST   8'h00
`define SSP_CONFIG_RST 8'h00
`define SSP_DATA_RST   8'h00
`define SSP_BITS       4'h8
`define SSP_HALF_R00   3'h1
`define SSP_HALF_R01   3'h2
`define SSP_HALF_R1X   3'h4

`endif

// >>> common/ssp_pkg.sv
package ssp_pkg;
  typedef enum logic [2:0] {
    SSP_IDLE = 3'b001,
    SSP_LOW  = 3'b010,
    SSP_HIGH = 3'b100
  } ssp_state_t;
  typedef logic [7:0] ssp_byte_t;
endpackage

// >>> common/ssp_shift_if.sv
`timescale 1ns/10ps
interface ssp_shift_if;
  logic tick;
  logic [1:0] rate;
  logic       run;
  modport src (input rate, input run, output tick);
  modport dst (output rate, output run, input tick);
endinterface

// >>> rtl/ssp_pin_sync.sv
`timescale 1ns/10ps
module ssp_pin_sync #(
  parameter int W = 2
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_reg;

  // Elaboration guard: a zero-width bus has nothing to carry
  if (W < 1) begin : g_bad_width
    $error("W must be at least 1");
  end

  // First stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s1_reg <= '0;
      q      <= '0;
    end else begin
      s1_reg <= d;
      q      <= s1_reg;
    end
  end
endmodule

// >>> rtl/ssp_rate_div.sv
`timescale 1ns/10ps
`include "ssp_defines.svh"
module ssp_rate_div (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  ssp_shift_if.src        sif
);
  import ssp_pkg::*;

  logic [2:0] cnt_reg;
  logic [2:0] half_w;
  logic       wrap_w;

  // Half period in cycles; period 2, 4 or 8
  assign half_w = sif.rate[1] ? `SSP_HALF_R1X :
                  (sif.rate[0] ? `SSP_HALF_R01 : `SSP_HALF_R00);
  assign wrap_w = (cnt_reg == (half_w - 3'h1));
  assign sif.tick = sif.run & wrap_w;

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !sif.run) begin
      cnt_reg <= 3'h0;
    end else begin
      cnt_reg <= wrap_w ? 3'h0 : cnt_reg + 3'h1;
    end
  end
endmodule

// >>> rtl/ssp_top.sv
`timescale 1ns/10ps
`include "ssp_defines.svh"
// Functional notes
// [RULE1] Eight-bit shift register with data in, data out and clock pins.
// [RULE2] Internal clock source means master; external clock means slave.
// [RULE3] Port works only with select bit set; select routes data and clock pins.
// [RULE4] Master clock period 2, 4 or 8 cycles from two rate bits.
// [RULE5] Writing busy to one starts shifting.
// [RULE6] Busy clears by itself after eight bits.
// [RULE7] Software clearing busy early stops shifting.
// [RULE8] Interrupt request after eight bits when enabled.
// [RULE9] Software loads data only while shift clock is low.
// [RULE10] Shift clock rests low when idle, both phases.
// [RULE11] Slave: set busy only while incoming clock is low.
// [RULE12] Master alone drives clock and starts every exchange.
// [RULE13] Slave software sets busy at once; repeat after eight pulses.
// [RULE14] Normal phase: sample on rising edge, output changes on falling.
// [RULE15] Register advances on each falling clock edge.
// [RULE16] Alternate phase: sample on falling edge, output changes on rising.
// [RULE17] Phase flag clear is normal, set is alternate.
// [RULE18] Phase flag sits in pin 6 config bit, cleared at reset.
// [RULE19] Master: software sets data and clock pin config bits.
// [RULE20] Slave: software clears clock pin bit, sets data pin bit.
// [RULE21] Data pin bit zero floats output; clock bit picks internal/external.
// [RULE22] Most significant bit out first, received bit into bit zero.
module ssp_top (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [3:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output logic      [31:0]      avs_readdata,
  output logic                  avs_waitrequest,
  output logic      [1:0]       avs_response,
  input  wire logic             serial_in,
  output ssp_pkg::ssp_byte_t    serial_out_o,
  output logic                  serial_out_oe,
  input  wire logic             shift_clock_pin_i,
  output logic                  shift_clock_pin_o,
  output logic                  shift_clock_pin_oe,
  output logic                  irq_req
);
  import ssp_pkg::*;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  ssp_byte_t  main_control_reg;
  ssp_byte_t  port_g_cfg_reg;
  ssp_byte_t  serial_shift_reg;
  ssp_byte_t  serial_shift_next;
  logic       busy_reg;
  logic       done_reg;
  logic [3:0] bit_cnt_reg;
  logic       sck_reg;
  logic       so_reg;
  logic       sample_reg;
  logic       ack_reg;
  logic       sk_prev_reg;
  ssp_state_t state_reg;

  ssp_shift_if sif ();

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] pins_s;
  logic       si_s;
  logic       sk_s;

  ssp_pin_sync #(.W(2)) i_ssp_pin_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       ({serial_in, shift_clock_pin_i}),
    .q       (pins_s)
  );
  assign si_s = pins_s[1];
  assign sk_s = pins_s[0];

  // ------------------------------------------------------------
  // Configuration decode
  // ------------------------------------------------------------
  logic sel_w;
  logic master_w;
  logic alt_w;
  logic so_en_w;
  logic irq_en_w;

  assign sel_w    = main_control_reg[`SSP_CTRL_SEL];                  // [RULE3]
  assign master_w = port_g_cfg_reg[`SSP_CFG_PIN5];                    // [RULE2] [RULE21]
  assign alt_w    = port_g_cfg_reg[`SSP_CFG_PIN6];                    // [RULE17] [RULE18]
  assign so_en_w  = port_g_cfg_reg[`SSP_CFG_PIN4];
  assign irq_en_w = main_control_reg[`SSP_CTRL_IRQ_EN];

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  logic wr_ctrl;
  logic wr_stat;
  logic wr_cfg;
  logic wr_data;
  logic hit_w;
  logic [31:0] rd_mux;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign hit_w   = (avs_address == `SSP_ADDR_CTRL) | (avs_address == `SSP_ADDR_STATUS) |
                   (avs_address == `SSP_ADDR_CONFIG) | (avs_address == `SSP_ADDR_DATA);
  assign wr_ctrl = avs_write & ack_reg & avs_byteenable[0] & (avs_address == `SSP_ADDR_CTRL);
  assign wr_stat = avs_write & ack_reg & avs_byteenable[0] & (avs_address == `SSP_ADDR_STATUS);
  assign wr_cfg  = avs_write & ack_reg & avs_byteenable[0] & (avs_address == `SSP_ADDR_CONFIG);
  // Loads only land safely while clock is low; software's duty
  assign wr_data = avs_write & ack_reg & avs_byteenable[0] & (avs_address == `SSP_ADDR_DATA); // [RULE9]
  assign rd_mux  = (avs_address == `SSP_ADDR_CTRL)   ? {24'h000000, main_control_reg} :
                   (avs_address == `SSP_ADDR_STATUS) ? {30'h00000000, done_reg, busy_reg} :
                   (avs_address == `SSP_ADDR_CONFIG) ? {24'h000000, port_g_cfg_reg} :
                   (avs_address == `SSP_ADDR_DATA)   ? {24'h000000, serial_shift_reg} : 32'h00000000;

  // One wait state: answer on second cycle of every request
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ack_reg      <= 1'b0;
      avs_readdata <= 32'h00000000;
      avs_response <= 2'h0;
    end else begin
      ack_reg      <= (avs_read | avs_write) & ~ack_reg;
      avs_readdata <= rd_mux;
      avs_response <= hit_w ? 2'h0 : 2'h2;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      main_control_reg <= `SSP_CTRL_RST;
      port_g_cfg_reg   <= `SSP_CONFIG_RST;                                // [RULE18]
    end else begin
      if (wr_ctrl) main_control_reg <= avs_writedata[7:0];
      if (wr_cfg)  port_g_cfg_reg   <= avs_writedata[7:0];
    end
  end

  // ------------------------------------------------------------
  // Shift clock edges
  // ------------------------------------------------------------
  logic rise_w;
  logic fall_w;
  logic sk_int_rise;
  logic sk_int_fall;

  assign sif.rate = {main_control_reg[`SSP_CTRL_RATE_HI], main_control_reg[`SSP_CTRL_RATE_LO]}; // [RULE4]
  assign sif.run  = busy_reg & sel_w & master_w;
  assign sk_int_rise = sif.tick & (state_reg == SSP_LOW);
  assign sk_int_fall = sif.tick & (state_reg == SSP_HIGH);
  // Slave follows synchronised external clock edges
  assign rise_w = master_w ? sk_int_rise : (sk_s & ~sk_prev_reg);     // [RULE2]
  assign fall_w = master_w ? sk_int_fall : (~sk_s & sk_prev_reg);

  // Sample and launch edges depend on phase
  logic samp_edge;
  logic launch_edge;
  logic shifting;
  logic last_w;

  assign shifting    = busy_reg & sel_w;
  assign samp_edge   = shifting & (alt_w ? fall_w : rise_w);          // [RULE14] [RULE16]
  assign launch_edge = shifting & (alt_w ? rise_w : fall_w);
  assign last_w      = shifting & fall_w & (bit_cnt_reg == (`SSP_BITS - 4'h1));

  // ------------------------------------------------------------
  // Input alignment
  // ------------------------------------------------------------
  // Data pin lags two cycles in its synchroniser; master edges do not
  // So master samples two cycles late; at the fastest rate or in alternate phase that is after the shift
  // The shift then leaves a hole in bit 0 (bit 1 if shifted again) for the late bit
  // Slave edges pass the same synchroniser as the data and need no delay
  logic [1:0] samp_dly_reg;
  logic       late_reg;
  logic       have_reg;
  logic       take_w;
  logic       start_w;
  logic       shift_in_w;
  ssp_byte_t  fill_next;

  assign take_w     = master_w ? samp_dly_reg[1] : samp_edge;
  assign start_w    = wr_stat & avs_writedata[`SSP_STAT_BUSY];
  assign shift_in_w = take_w ? si_s : (have_reg & sample_reg);
  assign serial_shift_next = (take_w & late_reg) ? {serial_shift_reg[5:0], si_s, 1'b0} :
                             {serial_shift_reg[6:0], shift_in_w};                  // [RULE15] [RULE22]
  assign fill_next  = {serial_shift_reg[7:1], si_s};

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      samp_dly_reg <= 2'h0;
      late_reg     <= 1'b0;
      have_reg     <= 1'b0;
    end else begin
      samp_dly_reg <= {samp_dly_reg[0], samp_edge};
      if (start_w) begin
        late_reg <= 1'b0;
        have_reg <= 1'b0;
      end else if (shifting & fall_w) begin
        late_reg <= take_w ? late_reg : ~have_reg;
        have_reg <= 1'b0;
      end else if (take_w) begin
        late_reg <= 1'b0;
        have_reg <= ~late_reg;
      end
    end
  end

  // ------------------------------------------------------------
  // Master clock generator
  // ------------------------------------------------------------
  ssp_rate_div i_ssp_rate_div (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .sif     (sif)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg   <= SSP_IDLE;
      sck_reg     <= 1'b0;
      sk_prev_reg <= 1'b0;
    end else begin
      sk_prev_reg <= sk_s;
      case (state_reg)
        SSP_IDLE: begin
          sck_reg <= 1'b0;                                            // [RULE10]
          if (sif.run) state_reg <= SSP_LOW;                          // [RULE12]
        end
        SSP_LOW: begin
          if (!sif.run) state_reg <= SSP_IDLE;
          else if (sif.tick) begin
            state_reg <= SSP_HIGH;
            sck_reg   <= 1'b1;
          end
        end
        SSP_HIGH: begin
          if (!sif.run) begin
            state_reg <= SSP_IDLE;
            sck_reg   <= 1'b0;
          end else if (sif.tick) begin
            state_reg <= SSP_LOW;
            sck_reg   <= 1'b0;
          end
        end
        default: begin
          state_reg <= SSP_IDLE;
          sck_reg   <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Shift engine and busy flag
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      serial_shift_reg <= `SSP_DATA_RST;
      sample_reg       <= 1'b0;
      bit_cnt_reg      <= 4'h0;
      busy_reg         <= 1'b0;
      done_reg         <= 1'b0;
    end else begin
      if (take_w) sample_reg <= si_s;                                 // [RULE14]
      if (wr_data) begin
        serial_shift_reg <= avs_writedata[7:0];
      end else if (shifting & fall_w) begin
        serial_shift_reg <= serial_shift_next;                        // [RULE15]
      end else if (take_w & late_reg) begin
        serial_shift_reg <= fill_next;                                // [RULE22]
      end
      if (last_w) begin
        busy_reg    <= 1'b0;                                          // [RULE6]
        done_reg    <= 1'b1;                                          // [RULE8]
        bit_cnt_reg <= 4'h0;
      end else if (wr_stat) begin
        busy_reg    <= avs_writedata[`SSP_STAT_BUSY];                 // [RULE5] [RULE7]
        bit_cnt_reg <= 4'h0;
        if (avs_writedata[`SSP_STAT_DONE]) done_reg <= 1'b0;
      end else if (shifting & fall_w) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
    end
  end

  // Output bit updates at launch edge; first bit shows from start
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      so_reg <= 1'b0;
    end else if (!shifting || launch_edge) begin
      so_reg <= (launch_edge && !alt_w) ? serial_shift_reg[6] : serial_shift_reg[7]; // [RULE22] [RULE16]
    end
  end

  // ------------------------------------------------------------
  // Pins
  // ------------------------------------------------------------
  assign serial_out_o       = {7'h00, so_reg};                        // [RULE1]
  assign serial_out_oe      = sel_w & so_en_w;                        // [RULE21] [RULE3]
  assign shift_clock_pin_o  = sck_reg;
  assign shift_clock_pin_oe = sel_w & master_w;                       // [RULE12]
  assign irq_req            = done_reg & irq_en_w;                    // [RULE8]
endmodule

// >>> tb/ssp_peer.sv
`timescale 1ns/10ps
module ssp_peer (
  input  wire logic sck,
  input  wire logic alt,
  input  wire logic so,
  output logic      si,
  output logic      sck_out
);
  logic [7:0] tx;
  logic [7:0] rx;
  initial begin
    si = 1'b0;
    sck_out = 1'b0;
    tx = 8'h00;
    rx = 8'h00;
  end
  task automatic load(input logic [7:0] b);
    tx = b;
    si <= b[7];
    rx = 8'h00;
  endtask
  // Clock only within a frame, idle low
  task automatic pulse(input int n);
    // Keep pin edges clear of the system clock edge
    #10;
    repeat (n) begin
      #160 sck_out = 1'b1;
      #160 sck_out = 1'b0;
    end
  endtask
  always @(posedge sck) begin
    if (alt) begin
      si = tx[7];
      tx = {tx[6:0], 1'b0};
    end else rx = {rx[6:0], so};
  end
  always @(negedge sck) begin
    if (alt) rx = {rx[6:0], so};
    else begin
      tx = {tx[6:0], 1'b0};
      si = tx[7];
    end
  end
endmodule

// >>> tb/ssp_properties.sv
`timescale 1ns/10ps
`include "ssp_defines.svh"
module ssp_properties (
  input wire logic               clk_sys,
  input wire logic               rst_n,
  input wire logic [3:0]         avs_address,
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic [31:0]        avs_writedata,
  input wire logic [3:0]         avs_byteenable,
  input wire logic [31:0]        avs_readdata,
  input wire logic               avs_waitrequest,
  input wire logic [1:0]         avs_response,
  input wire logic               serial_in,
  input wire ssp_pkg::ssp_byte_t serial_out_o,
  input wire logic               serial_out_oe,
  input wire logic               shift_clock_pin_i,
  input wire logic               shift_clock_pin_o,
  input wire logic               shift_clock_pin_oe,
  input wire logic               irq_req
);
  import ssp_pkg::*;
  logic [7:0] ctl_q;
  logic [7:0] cfg_q;
  logic [7:0] dat_q;
  logic [3:0] hi_n;
  logic [3:0] fal_n;
  logic       od;
  logic       id;
  logic       abr;
  wire        wr_ok = avs_write & ~avs_waitrequest & avs_byteenable[0];
  wire        st    = wr_ok & (avs_address == `SSP_ADDR_STATUS);
  wire        go    = st & avs_writedata[0];
  wire        ab    = st & ~avs_writedata[0];
  wire        fall  = shift_clock_pin_oe ? (od & ~shift_clock_pin_o) : (id & ~shift_clock_pin_i);
  wire  [3:0] half  = ctl_q[1] ? 4'h4 : (ctl_q[0] ? 4'h2 : 4'h1);
  // ----------
  // Shadow of what software wrote
  // ----------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctl_q <= 8'h00;
      cfg_q <= 8'h00;
      dat_q <= 8'h00;
      hi_n  <= 4'h0;
      fal_n <= 4'h0;
      od    <= 1'b0;
      id    <= 1'b0;
      abr   <= 1'b0;
    end else begin
      if (wr_ok && avs_address == `SSP_ADDR_CTRL) ctl_q <= avs_writedata[7:0];
      if (wr_ok && avs_address == `SSP_ADDR_CONFIG) cfg_q <= avs_writedata[7:0];
      if (wr_ok && avs_address == `SSP_ADDR_DATA) dat_q <= avs_writedata[7:0];
      hi_n  <= shift_clock_pin_o ? hi_n + 4'h1 : 4'h0;
      fal_n <= go ? 4'h0 : fal_n + {3'h0, fall & (fal_n != 4'hF)};
      od    <= shift_clock_pin_o;
      id    <= shift_clock_pin_i;
      abr   <= go ? 1'b0 : (abr | ab);
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_sck_oe; shift_clock_pin_oe == (ctl_q[2] & cfg_q[5]); endproperty
  property p_so_oe; serial_out_oe == (ctl_q[2] & cfg_q[4]); endproperty
  // Aborted frames may cut a high half short
  property p_rate; $fell(shift_clock_pin_o) && !abr |-> hi_n == half; endproperty
  property p_quiet; !shift_clock_pin_oe |-> !shift_clock_pin_o; endproperty
  property p_abort; ab |-> ##[1:4] !shift_clock_pin_o ##1 !shift_clock_pin_o [*8]; endproperty
  property p_irq_en; irq_req |-> ctl_q[3]; endproperty
  property p_irq8; $rose(irq_req) |-> fal_n + {3'h0, fall} == 4'h8; endproperty
  property p_first; $rose(shift_clock_pin_o) && fal_n == 4'h0 && !cfg_q[6] |-> serial_out_o[0] == dat_q[7];
  endproperty
  property p_norm; $rose(shift_clock_pin_o) && !cfg_q[6] |-> $stable(serial_out_o); endproperty
  property p_alt; $fell(shift_clock_pin_o) && cfg_q[6] && !abr |-> $stable(serial_out_o); endproperty
  a_sck_oe: assert property (p_sck_oe) else $error("clock enable wrong");
  a_so_oe: assert property (p_so_oe) else $error("data enable wrong");
  a_rate: assert property (p_rate) else $error("clock half wrong");
  a_quiet: assert property (p_quiet) else $error("clock runs in slave");
  a_abort: assert property (p_abort) else $error("clock after abort");
  a_irq_en: assert property (p_irq_en) else $error("irq not enabled");
  a_irq8: assert property (p_irq8) else $error("irq count wrong");
  a_first: assert property (p_first) else $error("first bit wrong");
  a_norm: assert property (p_norm) else $error("data moved on rise");
  a_alt: assert property (p_alt) else $error("data moved on fall");
  c_done: cover property (go ##[1:200] $rose(irq_req));
  c_slave: cover property ($fell(shift_clock_pin_i) && fal_n == 4'h7);
  c_abort: cover property (ab && fal_n > 4'h0);
endmodule
bind ssp_top ssp_properties i_ssp_properties (.*);

// >>> tb/sync_serial_shift_port_test.sv
`timescale 1ns/10ps
`include "ssp_defines.svh"
module sync_serial_shift_port_test;
  import ssp_pkg::*;
  logic        clk_sys;
  logic        rst_n;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  avs_response;
  logic        serial_in;
  ssp_byte_t   serial_out_o;
  logic        serial_out_oe;
  logic        sck_ext;
  logic        shift_clock_pin_o;
  logic        shift_clock_pin_oe;
  logic        irq_req;
  logic        alt_r;
  logic [31:0] rd_v;
  logic [34:0] ent;
  logic [34:0] exp_q[$];
  int          fail_count;
  int          n_checks;
  int          m;
  wire         link_sck = shift_clock_pin_oe ? shift_clock_pin_o : sck_ext;
  wire         so_w     = serial_out_oe ? serial_out_o[0] : 1'bz;
  ssp_top i_ssp_top (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .serial_in(serial_in), .serial_out_o(serial_out_o), .serial_out_oe(serial_out_oe),
    .shift_clock_pin_i(sck_ext), .shift_clock_pin_o(shift_clock_pin_o),
    .shift_clock_pin_oe(shift_clock_pin_oe), .irq_req(irq_req));
  ssp_peer i_ssp_peer (.sck(link_sck), .alt(alt_r), .so(so_w), .si(serial_in), .sck_out(sck_ext));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic stop_test;
    if (fail_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic fault(input string s);
    fail_count++;
    $display("[ERR] %0t %s", $time, s);
    stop_test();
  endtask
  task automatic cmp_rd(input logic [33:0] g, input logic [33:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t read %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_pin(input logic [7:0] g, input logic [7:0] e, input string s);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t %s %h exp %h", $time, s, g, e);
    end
  endtask
  // ----------
  // Bus master: hold until waitrequest low
  // ----------
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic c, input logic [33:0] e);
    int i;
    if (!w) exp_q.push_back({c, e});
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) fault("bus hang");
    rd_v = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 1'b1, {26'h0, e});
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 1'b0, 34'h0);
  endtask
  task automatic wait_done;
    int k;
    for (k = 0; k < 300; k++) begin
      bus(1'b0, `SSP_ADDR_STATUS, 8'h00, 1'b0, 34'h0);
      if (rd_v[0] === 1'b0) break;
    end
    if (k == 300) fault("busy stuck");
  endtask
  task automatic xfer(input logic [1:0] r, input logic a, input logic ms);
    logic [7:0] tx;
    logic [7:0] pt;
    tx = 8'($urandom);
    pt = 8'($urandom);
    alt_r <= a;
    wr(`SSP_ADDR_CONFIG, {1'b0, a, ms, 5'h10});
    wr(`SSP_ADDR_CTRL, {6'h03, r});
    wr(`SSP_ADDR_DATA, tx);
    i_ssp_peer.load(pt);
    wr(`SSP_ADDR_STATUS, 8'h01);
    if (!ms) fork i_ssp_peer.pulse(8); join_none
    wait_done();
    cmp_pin(8'(irq_req), 8'h01, "irq");
    rd(`SSP_ADDR_STATUS, 8'h02);
    rd(`SSP_ADDR_DATA, pt);
    cmp_pin(i_ssp_peer.rx, tx, "peer rx");
    wr(`SSP_ADDR_STATUS, 8'h02);
  endtask
  always @(posedge clk_sys) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      ent = exp_q.pop_front();
      if (ent[34]) cmp_rd({avs_response, avs_readdata}, ent[33:0]);
    end
  end
  initial begin
    rst_n = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    alt_r = 1'b0;
    fail_count = 0;
    n_checks = 0;
    void'($urandom(76964));
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(`SSP_ADDR_CTRL, 8'h00);
    rd(`SSP_ADDR_STATUS, 8'h00);
    rd(`SSP_ADDR_CONFIG, 8'h00);
    rd(`SSP_ADDR_DATA, 8'h00);
    bus(1'b0, 4'h2, 8'h00, 1'b1, {2'b10, 32'h0});
    avs_byteenable <= 4'h0;
    wr(`SSP_ADDR_CONFIG, 8'h40);
    avs_byteenable <= 4'hF;
    rd(`SSP_ADDR_CONFIG, 8'h00);
    for (m = 0; m < 4; m++) xfer(m[1:0], 1'b0, 1'b1);
    xfer(2'b11, 1'b1, 1'b1);
    xfer(2'b00, 1'b0, 1'b0);
    cmp_pin({6'h0, serial_out_oe, shift_clock_pin_oe}, 8'h02, "slave oe");
    wr(`SSP_ADDR_CONFIG, 8'h30);
    wr(`SSP_ADDR_CTRL, 8'h06);
    wr(`SSP_ADDR_DATA, 8'hA5);
    wr(`SSP_ADDR_STATUS, 8'h01);
    repeat (22) @(posedge clk_sys);
    wr(`SSP_ADDR_STATUS, 8'h00);
    repeat (12) @(posedge clk_sys);
    cmp_pin(8'(shift_clock_pin_o), 8'h00, "clock idle");
    rd(`SSP_ADDR_STATUS, 8'h00);
    wr(`SSP_ADDR_CTRL, 8'h00);
    cmp_pin({6'h0, serial_out_oe, shift_clock_pin_oe}, 8'h00, "oe off");
    wr(`SSP_ADDR_CONFIG, 8'h20);
    wr(`SSP_ADDR_CTRL, 8'h04);
    cmp_pin({6'h0, serial_out_oe, shift_clock_pin_oe}, 8'h01, "data float");
    stop_test();
  end
endmodule
